// >>> design/gpio_port_change_notify.sv
// Parallel ports A, B, D, E, F with change notification, AHB-Lite register slave
`include "gpio_port_change_notify_map.svh"
`default_nettype none
module gpio_port_change_notify
   import gpio_port_change_notify_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic [4:0][15:0] i_pin_in,
   output pin_drive_t o_pin,
   output logic [15:0] o_adc_connect,
   output logic [7:0] o_pullup_en,
   output logic o_change_irq_req,
   output logic o_change_wake
);
   localparam logic [4:0][15:0] PORT_MASK = {`MASK_F, `MASK_E, `MASK_D, `MASK_B, `MASK_A};
   localparam logic [4:0][15:0] DIR_RESET = {`RST_DIR_F, `RST_DIR_E, `RST_DIR_D, `RST_DIR_B, `RST_DIR_A};
   localparam logic [4:0][9:0] PORT_BASE = {`IDX_PORT_F_DIRECTION, `IDX_PORT_E_DIRECTION,
      `IDX_PORT_D_DIRECTION, `IDX_PORT_B_DIRECTION, `IDX_PORT_A_DIRECTION};
   localparam gpio_state_t ST_RESET = '{
      phase: BUS_IDLE,
      idx: 10'h000,
      hrdata: 32'h0000_0000,
      dir: DIR_RESET,
      lat: '0,
      sync1: '0,
      sync2: '0,
      sync3: '0,
      pin_lvl: '0,
      ansel: 16'h0000,
      cn_en: 8'h00,
      pu_en: 8'h00,
      cn_cap: 8'h00,
      cn_flag: 1'b0
   };

   gpio_state_t st;
   gpio_state_t st_nxt;
   reg_sel_t sel;
   logic [7:0] watch_lvl;
   logic [7:0] cn_change;
   logic addr_take;
   logic data_end;
   logic [31:0] rd_word;
   logic [15:0] wr_half;

   // Port registers sit at fixed offsets from each port's direction index
   function automatic reg_sel_t decode(input logic [9:0] idx);
      reg_sel_t r;
      r = '{hit: 1'b0, port: 3'h0, kind: KIND_MISC};
      for (int p = 0; p < 5; p++) begin
         if (idx == PORT_BASE[p]) begin
            r = '{hit: 1'b1, port: 3'(p), kind: KIND_DIR};
         end
         if (idx == PORT_BASE[p] + `OFS_PIN_VALUE) begin
            r = '{hit: 1'b1, port: 3'(p), kind: KIND_PIN};
         end
         if (idx == PORT_BASE[p] + `OFS_OUTPUT_LATCH) begin
            r = '{hit: 1'b1, port: 3'(p), kind: KIND_LAT};
         end
      end
      return r;
   endfunction

   // Watched inputs are port B bits 0..7
   assign watch_lvl = st.pin_lvl[1][`POS_WATCH_LO +: `NUM_WATCH];
   assign cn_change = st.cn_en & (watch_lvl ^ st.cn_cap);

   // Read wait state lets read data come from a flip-flop
   assign o_hreadyout = (st.phase != BUS_RD_WAIT);
   assign o_hresp = 1'b0;
   assign o_hrdata = st.hrdata;
   assign addr_take = i_hsel && i_htrans[1] && i_hready;
   assign data_end = (st.phase == BUS_WRITE) || (st.phase == BUS_RD_DONE);
   assign sel = decode(st.idx);
   assign wr_half = i_hwdata[15:0];

   // Pad drive from latch and direction
   assign o_pin.pin_out = st.lat;
   assign o_pin.pin_oe = ~st.dir & PORT_MASK;
   // Only analog-selected port B pins reach the converter
   assign o_adc_connect = st.ansel & PORT_MASK[1];
   assign o_pullup_en = st.pu_en;
   assign o_change_irq_req = st.cn_flag;
   // Unclocked compare keeps a wake source alive while the clock is stopped
   assign o_change_wake = |(st.cn_en & (i_pin_in[1][`POS_WATCH_LO +: `NUM_WATCH] ^ st.cn_cap));

   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel.hit) begin
         unique case (sel.kind)
            KIND_DIR: rd_word[15:0] = st.dir[sel.port];
            KIND_LAT: rd_word[15:0] = st.lat[sel.port];
            // Analog pins read as low on port B
            KIND_PIN: rd_word[15:0] = st.pin_lvl[sel.port] & ((sel.port == 3'h1) ? ~st.ansel : 16'hFFFF);
            KIND_MISC: rd_word = 32'h0000_0000;
         endcase
      end else begin
         unique case (st.idx)
            `IDX_ANALOG_PIN_SELECT: rd_word[15:0] = st.ansel;
            `IDX_CHANGE_IRQ_ENABLE: rd_word[7:0] = st.cn_en;
            `IDX_PULLUP_ENABLE: rd_word[7:0] = st.pu_en;
            `IDX_CHANGE_FLAG: rd_word[`POS_CHANGE_FLAG] = st.cn_flag;
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      st_nxt = st;
      // Three-flop synchroniser; a level counts once stages two and three agree
      st_nxt.sync1 = i_pin_in;
      st_nxt.sync2 = st.sync1;
      st_nxt.sync3 = st.sync2;
      for (int p = 0; p < 5; p++) begin
         for (int b = 0; b < 16; b++) begin
            if (st.sync2[p][b] == st.sync3[p][b]) begin
               st_nxt.pin_lvl[p][b] = st.sync3[p][b] & PORT_MASK[p][b];
            end
         end
      end
      // Recapture every cycle so a level change flags once
      st_nxt.cn_cap = watch_lvl;
      unique case (st.phase)
         BUS_IDLE: st_nxt.phase = BUS_IDLE;
         BUS_WRITE: st_nxt.phase = BUS_IDLE;
         BUS_RD_WAIT: begin
            st_nxt.hrdata = rd_word;
            st_nxt.phase = BUS_RD_DONE;
         end
         BUS_RD_DONE: st_nxt.phase = BUS_IDLE;
      endcase
      if (st.phase == BUS_WRITE) begin
         if (sel.hit) begin
            unique case (sel.kind)
               KIND_DIR: st_nxt.dir[sel.port] = wr_half & PORT_MASK[sel.port];
               KIND_PIN: st_nxt.lat[sel.port] = wr_half & PORT_MASK[sel.port];
               KIND_LAT: st_nxt.lat[sel.port] = wr_half & PORT_MASK[sel.port];
               KIND_MISC: st_nxt.lat[sel.port] = st.lat[sel.port];
            endcase
         end else begin
            unique case (st.idx)
               `IDX_ANALOG_PIN_SELECT: st_nxt.ansel = wr_half & PORT_MASK[1];
               `IDX_CHANGE_IRQ_ENABLE: st_nxt.cn_en = i_hwdata[7:0];
               `IDX_PULLUP_ENABLE: st_nxt.pu_en = i_hwdata[7:0];
               `IDX_CHANGE_FLAG: begin
                  if (i_hwdata[`POS_CHANGE_FLAG]) begin
                     st_nxt.cn_flag = 1'b0;
                  end
               end
               default: st_nxt.cn_flag = st.cn_flag;
            endcase
         end
      end
      // Set after clear so a change in the clearing cycle is kept
      if (|cn_change) begin
         st_nxt.cn_flag = 1'b1;
      end
      if ((st.phase == BUS_IDLE || data_end) && addr_take) begin
         st_nxt.idx = (i_haddr[31:12] == 20'h00000 && i_haddr[1:0] == 2'b00) ? i_haddr[11:2] : 10'h000;
         st_nxt.phase = i_hwrite ? BUS_WRITE : BUS_RD_WAIT;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         st <= ST_RESET;
      end else if (i_ce) begin
         st <= st_nxt;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_analog_reads_zero: assert property (
      (st.phase == BUS_RD_WAIT && i_ce && sel.hit && sel.kind == KIND_PIN && sel.port == 3'h1)
      |=> ((st.hrdata[15:0] & $past(st.ansel)) == 16'h0000))
      else $error("analog pin read back nonzero");

   a_dir_drives_oe: assert property (
      o_pin.pin_oe == (~st.dir & PORT_MASK))
      else $error("output enable disagrees with direction");

   a_unimpl_bits_zero: assert property (
      ((st.dir & ~PORT_MASK) == '0) && ((st.lat & ~PORT_MASK) == '0) && ((st.pin_lvl & ~PORT_MASK) == '0))
      else $error("unimplemented port bit is set");

   a_change_sets_flag: assert property (
      (i_ce && |cn_change) |=> st.cn_flag && o_change_irq_req)
      else $error("enabled change did not raise request");

   a_flag_set_wins: assert property (
      (i_ce && |cn_change && st.phase == BUS_WRITE && st.idx == `IDX_CHANGE_FLAG)
      |=> st.cn_flag)
      else $error("change lost against flag clear");

   a_disabled_no_flag: assert property (
      (i_ce && st.cn_en == 8'h00 && !st.cn_flag && st.phase != BUS_WRITE) |=> !st.cn_flag)
      else $error("flag raised with all enables clear");

   a_wake_follows_pins: assert property (
      o_change_wake == |(st.cn_en & (i_pin_in[1][7:0] ^ st.cn_cap)))
      else $error("sleep wake source wrong");

   a_pullup_follows: assert property (
      (i_ce && st.phase == BUS_WRITE && st.idx == `IDX_PULLUP_ENABLE)
      |=> o_pullup_en == $past(i_hwdata[7:0]))
      else $error("pull-up enable not written");

   a_pin_write_latch: assert property (
      (i_ce && st.phase == BUS_WRITE && sel.hit && sel.kind == KIND_PIN && sel.port == 3'h1)
      |=> st.lat[1] == ($past(i_hwdata[15:0]) & `MASK_B))
      else $error("pin value write missed latch");

   a_adc_only_analog: assert property (
      (o_adc_connect & ~st.ansel) == 16'h0000)
      else $error("digital pin on converter path");

   a_reset_dir: assert property (
      $past(!i_rst_b) |-> (st.dir == DIR_RESET && st.lat == '0 && !st.cn_flag))
      else $error("reset values wrong");

   a_sync_latency: assert property (
      (i_ce && st.sync2 == st.sync3) ##1 i_ce |-> st.pin_lvl == ($past(st.sync3) & PORT_MASK))
      else $error("pin level not from synchroniser");

   a_read_wait_one: assert property (
      (i_ce && st.phase == BUS_RD_WAIT) |=> o_hreadyout)
      else $error("read wait longer than one cycle");
endmodule
`default_nettype wire

// >>> design/gpio_port_change_notify_map.svh
// Register indices, field positions, reset values and masks of the parallel port block
`ifndef GPIO_PORT_CHANGE_NOTIFY_MAP_SVH
`define GPIO_PORT_CHANGE_NOTIFY_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_PORT_A_DIRECTION 10'h2C0
`define IDX_PORT_A_PIN_VALUE 10'h2C2
`define IDX_PORT_A_OUTPUT_LATCH 10'h2C4
`define IDX_PORT_B_DIRECTION 10'h2C6
`define IDX_PORT_B_PIN_VALUE 10'h2C8
`define IDX_PORT_B_OUTPUT_LATCH 10'h2CA
`define IDX_PORT_D_DIRECTION 10'h2D2
`define IDX_PORT_D_PIN_VALUE 10'h2D4
`define IDX_PORT_D_OUTPUT_LATCH 10'h2D6
`define IDX_PORT_E_DIRECTION 10'h2D8
`define IDX_PORT_E_PIN_VALUE 10'h2DA
`define IDX_PORT_E_OUTPUT_LATCH 10'h2DC
`define IDX_PORT_F_DIRECTION 10'h2DE
`define IDX_PORT_F_PIN_VALUE 10'h2E0
`define IDX_PORT_F_OUTPUT_LATCH 10'h2E2
`define IDX_ANALOG_PIN_SELECT 10'h2F0
`define IDX_CHANGE_IRQ_ENABLE 10'h2F2
`define IDX_PULLUP_ENABLE 10'h2F4
`define IDX_CHANGE_FLAG 10'h2F6

// Offsets of pin value and latch from a port's direction index
`define OFS_PIN_VALUE 10'h002
`define OFS_OUTPUT_LATCH 10'h004

// Direction reset values
`define RST_DIR_A 16'h0200
`define RST_DIR_B 16'hFC00
`define RST_DIR_D 16'h0001
`define RST_DIR_E 16'h00FF
`define RST_DIR_F 16'h01C0

// Implemented bits of each port
`define MASK_A 16'h0200
`define MASK_B 16'hFCFF
`define MASK_D 16'h0001
`define MASK_E 16'h00FF
`define MASK_F 16'h01C0

// Change flag bit and watched pin field (port B bits)
`define POS_CHANGE_FLAG 0
`define POS_WATCH_LO 0
`define NUM_WATCH 8

`endif

// >>> design/gpio_port_change_notify_pkg.sv
// Types of the parallel port block
`default_nettype none
package gpio_port_change_notify_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_RD_WAIT = 2'b10,
      BUS_RD_DONE = 2'b11
   } bus_phase_t;

   typedef enum logic [1:0] {
      KIND_DIR = 2'b00,
      KIND_PIN = 2'b01,
      KIND_LAT = 2'b10,
      KIND_MISC = 2'b11
   } reg_kind_t;

   typedef struct packed {
      logic hit;
      logic [2:0] port;
      reg_kind_t kind;
   } reg_sel_t;

   typedef struct packed {
      logic [4:0][15:0] pin_out;
      logic [4:0][15:0] pin_oe;
   } pin_drive_t;

   typedef struct packed {
      bus_phase_t phase;
      logic [9:0] idx;
      logic [31:0] hrdata;
      logic [4:0][15:0] dir;
      logic [4:0][15:0] lat;
      logic [4:0][15:0] sync1;
      logic [4:0][15:0] sync2;
      logic [4:0][15:0] sync3;
      logic [4:0][15:0] pin_lvl;
      logic [15:0] ansel;
      logic [7:0] cn_en;
      logic [7:0] pu_en;
      logic [7:0] cn_cap;
      logic cn_flag;
   } gpio_state_t;
endpackage
`default_nettype wire

// >>> tb/gpio_pin_model.sv
// Pads of the five ports as seen from outside: port drive, outside world, pull-ups
`default_nettype none
module gpio_pin_model
   import gpio_port_change_notify_pkg::*;
(
   input wire logic i_clk,
   input wire pin_drive_t i_pin,
   input wire logic [7:0] i_pullup_en,
   input wire logic [4:0][15:0] i_ext_lvl,
   input wire logic [4:0][15:0] i_ext_en,
   output logic [4:0][15:0] o_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip_r = 1'b0;
   always_ff @(posedge i_clk) begin
      flip_r <= ~flip_r;
   end
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         for (int b = 0; b < 16; b++) begin
            if (i_pin.pin_oe[p][b]) begin
               o_lvl[p][b] = i_pin.pin_out[p][b];
            end else if (i_ext_en[p][b]) begin
               o_lvl[p][b] = i_ext_lvl[p][b];
            end else if (p == 1 && b < 8 && i_pullup_en[b % 8]) begin
               o_lvl[p][b] = 1'b1;
            end else begin
               // Floating pad: never hand back a stale level
               o_lvl[p][b] = flip_r;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/gpio_port_change_notify_bench.sv
// Self-checking bench of the parallel port block
`include "gpio_port_change_notify_map.svh"
`default_nettype none
module gpio_port_change_notify_bench
   import gpio_port_change_notify_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0, i_rst_b = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'b00;
   logic hreadyout, hresp, irq, wake;
   logic [4:0][15:0] pins, ext_lvl = '0, ext_en = '1;
   pin_drive_t pin_drv;
   logic [15:0] adc;
   logic [7:0] pu;
   int err_total = 0, tests_run = 0, cycles = 0;
   logic [31:0] rd;
   localparam logic [9:0] DIR_IDX [5] = '{`IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION,
      `IDX_PORT_D_DIRECTION, `IDX_PORT_E_DIRECTION, `IDX_PORT_F_DIRECTION};
   localparam logic [15:0] MSK [5] = '{`MASK_A, `MASK_B, `MASK_D, `MASK_E, `MASK_F};
   localparam logic [15:0] RST [5] = '{`RST_DIR_A, `RST_DIR_B, `RST_DIR_D, `RST_DIR_E, `RST_DIR_F};

   gpio_port_change_notify DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_pin_in(pins), .o_pin(pin_drv), .o_adc_connect(adc), .o_pullup_en(pu),
      .o_change_irq_req(irq), .o_change_wake(wake));
   gpio_pin_model pads (.i_clk(i_clk), .i_pin(pin_drv), .i_pullup_en(pu), .i_ext_lvl(ext_lvl),
      .i_ext_en(ext_en), .o_lvl(pins));

   initial begin
      forever #20 i_clk = ~i_clk;
   end

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single-word transfer; ready is looked at mid-cycle, so it is the value the edge sees
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      logic r;
      @(posedge i_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, idx, 2'b00};
      do begin
         @(negedge i_clk);
         r = hreadyout;
         @(posedge i_clk);
      end while (r !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(negedge i_clk);
         r = hreadyout;
         rd = hrdata;
         @(posedge i_clk);
      end while (r !== 1'b1);
      // Outputs launched by the closing edge are only settled half a cycle later
      @(negedge i_clk);
   endtask

   task automatic t_reset();
      for (int p = 0; p < 5; p++) begin
         bus(0, DIR_IDX[p], 0);
         chk(rd, {16'h0, RST[p]});
         bus(0, DIR_IDX[p] + `OFS_OUTPUT_LATCH, 0);
         chk(rd, 0);
         bus(0, DIR_IDX[p] + `OFS_PIN_VALUE, 0);
         chk(rd, 0);
         // Port B low byte resets with direction zero, so it drives
         chk(pin_drv.pin_oe[p], ~RST[p] & MSK[p]);
      end
   endtask

   task automatic t_latch();
      for (int p = 0; p < 5; p++) begin
         bus(1, DIR_IDX[p] + `OFS_OUTPUT_LATCH, 32'h0000_FFFF);
         bus(0, DIR_IDX[p] + `OFS_OUTPUT_LATCH, 0);
         chk(rd, {16'h0, MSK[p]});
         bus(1, DIR_IDX[p] + `OFS_PIN_VALUE, 0);
         bus(0, DIR_IDX[p] + `OFS_OUTPUT_LATCH, 0);
         chk(rd, 0);
         bus(1, DIR_IDX[p], 0);
         chk(pin_drv.pin_oe[p], MSK[p]);
         bus(1, DIR_IDX[p], 32'h0000_FFFF);
         bus(0, DIR_IDX[p], 0);
         chk(rd, {16'h0, MSK[p]});
      end
   endtask

   task automatic t_pin();
      bus(1, `IDX_PORT_B_DIRECTION, 0);
      bus(1, `IDX_PORT_B_OUTPUT_LATCH, 32'h0000_5A5A);
      repeat (6) @(posedge i_clk);
      bus(0, `IDX_PORT_B_PIN_VALUE, 0);
      chk(rd, 32'h0000_585A);
      bus(1, `IDX_PORT_B_DIRECTION, 32'h0000_FFFF);
      @(posedge i_clk);
      ext_lvl[1] <= 16'hFFFF;
      repeat (6) @(posedge i_clk);
      bus(0, `IDX_PORT_B_PIN_VALUE, 0);
      chk(rd, {16'h0, `MASK_B});
      bus(1, `IDX_ANALOG_PIN_SELECT, 32'h0000_00F0);
      chk(adc, 16'h00F0);
      bus(0, `IDX_PORT_B_PIN_VALUE, 0);
      chk(rd, 32'h0000_FC0F);
      bus(1, `IDX_ANALOG_PIN_SELECT, 0);
      @(posedge i_clk);
      ext_lvl[1] <= 16'h0000;
   endtask

   task automatic t_change();
      for (int b = 0; b < 8; b++) begin
         bus(1, `IDX_CHANGE_IRQ_ENABLE, 32'h1 << b);
         bus(1, `IDX_CHANGE_FLAG, 1);
         @(posedge i_clk);
         ext_lvl[1][(b + 1) % 8] <= ~ext_lvl[1][(b + 1) % 8];
         repeat (8) @(posedge i_clk);
         chk(irq, 0);
         ext_lvl[1][b] <= ~ext_lvl[1][b];
         repeat (8) @(posedge i_clk);
         chk(irq, 1);
         bus(0, `IDX_CHANGE_FLAG, 0);
         chk(rd, 1);
         bus(1, `IDX_CHANGE_FLAG, 1);
         @(negedge i_clk);
         chk(irq, 0);
      end
      @(posedge i_clk);
      ce <= 1'b0;
      ext_lvl[1][7] <= ~ext_lvl[1][7];
      @(negedge i_clk);
      chk(wake, 1);
      @(posedge i_clk);
      ext_lvl[1][7] <= ~ext_lvl[1][7];
      @(negedge i_clk);
      chk(wake, 0);
      @(posedge i_clk);
      ce <= 1'b1;
   endtask

   task automatic t_misc();
      bus(1, `IDX_PULLUP_ENABLE, 32'h0000_00A5);
      chk(pu, 8'hA5);
      bus(0, `IDX_CHANGE_IRQ_ENABLE, 0);
      chk(rd, 32'h80);
      bus(1, `IDX_PULLUP_ENABLE, 0);
      bus(1, `IDX_CHANGE_FLAG + 10'h001, 32'hFFFF_FFFF);
      bus(0, `IDX_CHANGE_FLAG + 10'h001, 0);
      chk(rd, 0);
      chk(hresp, 0);
   endtask

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_latch();
      t_pin();
      t_change();
      t_misc();
      finish_test();
   end
endmodule
`default_nettype wire
